// *** rtl/mprs_card.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// R1 - supply applied starts power-on automatically
// R2 - no host access during initialization
// R3 - monitor high once pins configured
// R4 - operational no earlier than 20 s
// R5 - host keeps radio-disable high to start
// R6 - host holds reset low 200 ms
// R7 - host restarts only as emergency exit
// R8 - host drives reset open-collector only
// R9 - host board always controls reset line
// R10 - radio-disable low during restart: stay off
// R11 - radio-disable low turns off, else repower
// R12 - shutdown finalizes, then monitor goes low
// R13 - host watches monitor, not fixed delay
// R14 - host removes supply only after power-off
// R15 - host keeps pins low while off
// R16 - card makes its own power-on reset
// R17 - reset low halts; release restarts (the code ignores reset during finalization and once stayed down)
// R18 - host waits monitor high, else failure
module mprs_card #(
    parameter int unsigned INIT_CYC = mprs_pkg::INIT_CYC, // start-up interval
    parameter int unsigned CFG_CYC  = mprs_pkg::CFG_CYC,  // pin configuration time
    parameter int unsigned SHUT_CYC = mprs_pkg::SHUT_CYC  // finalization length
) (
    input  wire logic CLK,              // 50 MHz system clock
    input  wire logic RST_N,            // synchronous reset, active low
    mprs_if.card      PINS,             // pins toward the host
    output logic      ACTIVE,           // card operational
    output logic      OFF               // card is powered off
);

    // off, internal power-on reset, start-up, serving, held in reset,
    // finalizing after shutdown, stayed down until the supply is cycled
    typedef enum logic [2:0] {
        ST_OFF,
        ST_POR,
        ST_INIT,
        ST_ACTIVE,
        ST_HALT,
        ST_FINAL,
        ST_DOWN
    } mprs_state_type;

    // all card state in one word, registered as a whole
    typedef struct packed {
        logic [1:0]                 sup_s;      // supply synchroniser
        logic [1:0]                 rst_s;      // card reset synchroniser
        logic [1:0]                 dis_s;      // radio-disable synchroniser
        mprs_state_type             st;         // sequencer state
        logic [mprs_pkg::CNT_W-1:0] cnt;        // interval counter
        logic                       mon;        // power monitor level
        logic                       rdy;        // host access allowed
        logic                       off;        // powered off or stayed down
    } mprs_card_type;

    // state, synchroniser taps and shared counter decode
    mprs_card_type              s_q;
    mprs_card_type              s_d;
    logic [2:0]                 pin_raw;     // asynchronous pins, one per bit
    logic [2:0]                 pin_meta;    // first stages, read by the second only
    logic [2:0]                 pin_sync;    // second stages, safe to decode
    logic [2:0][1:0]            sync_nx;     // next value of each synchroniser
    logic                       sup;         // supply seen
    logic                       rst_n_line;  // card reset line seen
    logic                       dis_n;       // radio-disable seen
    logic [mprs_pkg::CNT_W-1:0] cnt_inc;     // counter plus one
    logic                       cfg_done;    // pin configuration interval over
    logic                       init_done;   // start-up interval over
    logic                       shut_done;   // finalization interval over

    // pins in bit order: supply, card reset line, radio-disable
    assign pin_raw  = {PINS.radio_disable_n, PINS.card_reset_n, PINS.main_supply_input};
    assign pin_meta = {s_q.dis_s[0], s_q.rst_s[0], s_q.sup_s[0]};
    assign pin_sync = {s_q.dis_s[1], s_q.rst_s[1], s_q.sup_s[1]};

    // two flip-flops per pin; nothing but the second stage reads the first
    for (genvar g = 0; g < 3; g++) begin : g_sync
        assign sync_nx[g] = {pin_meta[g], pin_raw[g]};
    end

    assign sup        = pin_sync[0];
    assign rst_n_line = pin_sync[1];
    assign dis_n      = pin_sync[2];

    // one adder shared by every counting state; compares are unsigned
    assign cnt_inc   = s_q.cnt + 32'h0000_0001;
    assign cfg_done  = (cnt_inc >= CFG_CYC);
    assign init_done = (cnt_inc >= INIT_CYC);
    assign shut_done = (cnt_inc >= SHUT_CYC);

    // sequencer; supply loss always drops to off regardless of state
    always_comb begin
        s_d       = s_q;
        s_d.sup_s = sync_nx[0];
        s_d.rst_s = sync_nx[1];
        s_d.dis_s = sync_nx[2];
        s_d.rdy   = 1'b0;
        if (!sup) begin
            s_d.st  = ST_OFF;
            s_d.cnt = mprs_pkg::CNT_RST;
            s_d.mon = 1'b0;
        end else begin
            unique case (s_q.st)
                ST_OFF: begin
                    // supply alone starts the card, no pulse needed
                    s_d.st  = ST_POR; // R1
                    s_d.cnt = mprs_pkg::CNT_RST;
                end

                ST_POR: begin
                    // internal power-on reset, reset line ignored here
                    s_d.st  = ST_INIT; // R16
                    s_d.cnt = mprs_pkg::CNT_RST;
                end

                ST_INIT: begin
                    // host access stays refused until the interval ends
                    s_d.cnt = cnt_inc;
                    if (cfg_done) begin
                        s_d.mon = 1'b1; // R3
                    end
                    if (!rst_n_line) begin
                        s_d.st = ST_HALT; // R17
                    end else if (init_done) begin
                        s_d.st = ST_ACTIVE; // R4
                    end
                end

                ST_ACTIVE: begin
                    // a shutdown pulse is only taken while serving
                    // reset wins over a shutdown pulse in the same cycle
                    s_d.rdy = 1'b1; // R2
                    if (!rst_n_line) begin
                        s_d.st  = ST_HALT; // R17
                        s_d.rdy = 1'b0;
                    end else if (PINS.shutdown_command) begin
                        s_d.st  = ST_FINAL; // R12
                        s_d.cnt = mprs_pkg::CNT_RST;
                        s_d.rdy = 1'b0;
                    end
                end

                ST_HALT: begin
                    // all operation stopped while the line is held low
                    if (rst_n_line) begin
                        if (!dis_n) begin
                            s_d.st  = ST_DOWN; // R10
                            s_d.mon = 1'b0;
                        end else begin
                            // restart without any detach, back to start-up
                            s_d.st  = ST_INIT; // R17
                            s_d.cnt = mprs_pkg::CNT_RST;
                            s_d.mon = 1'b0;
                        end
                    end
                end

                ST_FINAL: begin
                    // length is not defined; modelled as a fixed count
                    s_d.cnt = cnt_inc;
                    if (shut_done) begin
                        s_d.mon = 1'b0; // R12
                        s_d.cnt = mprs_pkg::CNT_RST;
                        // radio-disable decides between repower and staying off
                        if (dis_n) begin
                            s_d.st = ST_INIT; // R11
                        end else begin
                            s_d.st = ST_DOWN; // R11
                        end
                    end
                end

                ST_DOWN: begin
                    // stays off until supply is cycled
                    s_d.mon = 1'b0; // R10
                end

                default: begin
                    // unused state code: fall back to off, monitor low
                    s_d.st  = ST_OFF;
                    s_d.mon = 1'b0;
                end
            endcase
        end
        // registered so the off flag moves with the state it reports
        s_d.off = (s_d.st == ST_OFF) || (s_d.st == ST_DOWN);
    end

    // synchronous reset; synchroniser stages start at each pin's idle level
    // so no false edge is seen on the first cycles after release
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s_q.sup_s <= 2'h0;
            s_q.rst_s <= 2'h3;
            s_q.dis_s <= 2'h3;
            s_q.st    <= ST_OFF;
            s_q.cnt   <= mprs_pkg::CNT_RST;
            s_q.mon   <= 1'b0;
            s_q.rdy   <= 1'b0;
            s_q.off   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign PINS.power_monitor_output = s_q.mon;
    assign PINS.cmd_ready            = s_q.rdy;
    assign ACTIVE                    = s_q.rdy;
    assign OFF                       = s_q.off;
endmodule

// *** rtl/mprs_pkg.sv ***
package mprs_pkg;
    // timing, all derived from the 50 MHz system clock
    localparam int unsigned CLK_HZ            = 50_000_000;
    localparam int unsigned INIT_TIME_MS      = 20_000;    // start-up to activation
    localparam int unsigned RESET_HOLD_MS     = 200;       // least card reset low time
    localparam int unsigned SHUT_TIME_MS      = 15_000;    // typical finalization time
    localparam int unsigned CFG_TIME_MS       = 1_000;     // pins configured, monitor high
    localparam int unsigned INIT_CYC          = INIT_TIME_MS / 1000 * CLK_HZ;
    localparam int unsigned RESET_HOLD_CYC    = RESET_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned SHUT_CYC          = SHUT_TIME_MS / 1000 * CLK_HZ;
    localparam int unsigned CFG_CYC           = CFG_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W             = 32;
    localparam logic [31:0] CNT_RST           = 32'h0000_0000;
endpackage

// *** rtl/mprs_if.sv ***
`timescale 1ns/1ps
// pins between the card and the host board
interface mprs_if;
    logic main_supply_input;        // supply applied to the card
    logic card_reset_n_oe;          // host open-collector pulls reset low
    logic card_reset_n;             // resolved reset line level
    logic radio_disable_n;          // host radio-disable level
    logic power_monitor_output;     // card power monitor
    logic shutdown_command;         // one-cycle shutdown request pulse
    logic cmd_ready;                // card accepts host accesses

    // open-drain line with on-card pull: low only while host sinks it
    assign card_reset_n = ~card_reset_n_oe;

    modport card (
        input  main_supply_input,
        input  card_reset_n,
        input  radio_disable_n,
        input  shutdown_command,
        output power_monitor_output,
        output cmd_ready
    );
    modport host (
        output main_supply_input,
        output card_reset_n_oe,
        output radio_disable_n,
        output shutdown_command,
        input  power_monitor_output,
        input  cmd_ready
    );
endinterface

// *** rtl/mprs_host.sv ***
`timescale 1ns/1ps
// host board controller driving the card pins
module mprs_host #(
    parameter int unsigned INIT_CYC = mprs_pkg::INIT_CYC,      // start-up interval; timeout is twice this
    parameter int unsigned HOLD_CYC = mprs_pkg::RESET_HOLD_CYC // reset low time
) (
    input  wire logic CLK,              // 50 MHz system clock
    input  wire logic RST_N,            // synchronous reset, active low
    mprs_if.host      PINS,             // pins toward the card
    input  wire logic SUPPLY_EN,        // user wants supply applied
    input  wire logic RESTART_REQ,      // pulse: emergency restart
    input  wire logic SHUTDOWN_REQ,     // pulse: orderly shutdown
    input  wire logic RADIO_OFF,        // hold radio-disable low
    output logic      READY,            // card up, commands allowed
    output logic      START_FAIL,       // monitor never rose
    output logic      POWERED_OFF       // card reported off
);
    typedef enum logic [2:0] {
        H_OFF, H_WAIT, H_UP, H_RST, H_SHUT, H_DONE
    } mprs_hstate_type;

    typedef struct packed {
        logic [1:0]      mon_s;    // monitor synchroniser
        mprs_hstate_type st;
        logic [31:0]     cnt;
        logic            sup;
        logic            rst_oe;
        logic            dis_n;
        logic            cmd;
        logic            fail;
    } mprs_host_type;

    mprs_host_type s_q;
    mprs_host_type s_d;
    logic          mon;

    assign mon = s_q.mon_s[1];

    // host sequence; restart only from the up state as an emergency exit
    always_comb begin
        s_d       = s_q;
        s_d.mon_s = {s_q.mon_s[0], PINS.power_monitor_output};
        s_d.cmd   = 1'b0;
        s_d.dis_n = ~RADIO_OFF; // R5 R11
        unique case (s_q.st)
            H_OFF: begin
                s_d.rst_oe = 1'b0;
                if (SUPPLY_EN) begin
                    s_d.sup  = 1'b1;
                    s_d.st   = H_WAIT;
                    s_d.cnt  = mprs_pkg::CNT_RST;
                    s_d.fail = 1'b0;
                end
            end
            H_WAIT: begin
                s_d.cnt = s_q.cnt + 32'h0000_0001;
                if (mon && PINS.cmd_ready) begin
                    s_d.st = H_UP; // R18
                end else if (s_q.cnt + 32'h0000_0001 >= INIT_CYC + INIT_CYC) begin
                    s_d.fail = 1'b1; // R18
                end
            end
            H_UP: begin
                if (RESTART_REQ) begin
                    s_d.st     = H_RST; // R7 R9
                    s_d.cnt    = mprs_pkg::CNT_RST;
                    s_d.rst_oe = 1'b1; // R8
                end else if (SHUTDOWN_REQ) begin
                    s_d.cmd = 1'b1;
                    s_d.st  = H_SHUT;
                end
            end
            H_RST: begin
                s_d.cnt = s_q.cnt + 32'h0000_0001;
                if (s_q.cnt + 32'h0000_0001 >= HOLD_CYC) begin
                    s_d.rst_oe = 1'b0; // R6
                    s_d.st     = H_WAIT;
                    s_d.cnt    = mprs_pkg::CNT_RST;
                end
            end
            H_SHUT: begin
                // no fixed delay: wait for the monitor to fall
                if (!mon) begin
                    s_d.st = H_DONE; // R13
                end
            end
            H_DONE: begin
                s_d.sup = 1'b0; // R14
                if (!SUPPLY_EN) begin
                    s_d.st = H_OFF;
                end
            end
            default: s_d.st = H_OFF;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s_q.mon_s  <= 2'h0;
            s_q.st     <= H_OFF;
            s_q.cnt    <= mprs_pkg::CNT_RST;
            s_q.sup    <= 1'b0;
            s_q.rst_oe <= 1'b0;
            s_q.dis_n  <= 1'b1;
            s_q.cmd    <= 1'b0;
            s_q.fail   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // while the supply is removed, radio-disable is kept low to avoid back power
    assign PINS.main_supply_input = s_q.sup;
    assign PINS.card_reset_n_oe   = s_q.rst_oe;
    assign PINS.radio_disable_n   = s_q.dis_n & s_q.sup; // R15
    assign PINS.shutdown_command  = s_q.cmd;
    assign READY                  = (s_q.st == H_UP);
    assign START_FAIL             = s_q.fail;
    assign POWERED_OFF            = (s_q.st == H_DONE) || (s_q.st == H_OFF);
endmodule

// *** verif/mprs_monitor.sv ***
`timescale 1ns/1ps
// watches the pins between card and host
module mprs_monitor #(
    parameter int INIT_CYC = 200, // start-up interval
    parameter int CFG_CYC  = 20,  // pin configuration time
    parameter int SHUT_CYC = 50,  // finalization length
    parameter int HOLD_CYC = 10   // host reset low time
) (
    input wire logic CLK,                  // system clock
    input wire logic RST_N,                // sync reset, active low
    input wire logic main_supply_input,    // supply to the card
    input wire logic card_reset_n_oe,      // host sinks reset
    input wire logic card_reset_n,         // resolved reset line
    input wire logic radio_disable_n,      // radio-disable level
    input wire logic power_monitor_output, // card power monitor
    input wire logic shutdown_command,     // shutdown pulse
    input wire logic cmd_ready             // card accepts access
);
    localparam int CFG_MAX = CFG_CYC + 8;
    localparam int SHUT_A  = SHUT_CYC - 12;
    localparam int SHUT_B  = SHUT_CYC + 4;
    int sup_cnt_q;
    int hold_cnt_q;

    // cycles of supply and of reset sinking, counters avoid long repeats
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sup_cnt_q  <= 0;
            hold_cnt_q <= 0;
        end else begin
            sup_cnt_q  <= main_supply_input ? sup_cnt_q + 1 : 0;
            hold_cnt_q <= card_reset_n_oe ? hold_cnt_q + 1 : 0;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence fin_hold;
        power_monitor_output [*8];
    endsequence
    sequence down_hold;
        !power_monitor_output [*8];
    endsequence

    ready_mon_a: assert property (cmd_ready |-> power_monitor_output)
        else $error("ready while monitor low");
    ready_late_a: assert property (cmd_ready |-> sup_cnt_q >= INIT_CYC)
        else $error("ready too soon after supply");
    cmd_ready_a: assert property (shutdown_command |-> cmd_ready)
        else $error("command sent while card not ready");
    supply_safe_a: assert property ($fell(main_supply_input) |-> !$past(power_monitor_output))
        else $error("supply removed while monitor high");
    hold_len_a: assert property ($fell(card_reset_n_oe) |-> hold_cnt_q >= HOLD_CYC)
        else $error("reset pulse too short");
    halt_a: assert property ($fell(card_reset_n) |-> ##5 !cmd_ready [*8])
        else $error("card kept running under reset");
    power_on_a: assert property ($rose(main_supply_input) |-> ##[1:CFG_MAX] power_monitor_output)
        else $error("no automatic start-up");
    stay_down_a: assert property ($fell(power_monitor_output) && !radio_disable_n |-> ##1 down_hold)
        else $error("card came back with radio disabled");
    shut_fin_a: assert property (shutdown_command && cmd_ready |-> ##1 fin_hold ##[SHUT_A:SHUT_B] !power_monitor_output)
        else $error("finalization length wrong");
    pins_low_off_a: assert property (!main_supply_input |-> !radio_disable_n)
        else $error("high level driven toward unpowered card");
endmodule

// *** verif/mprs_bench.sv ***
`timescale 1ns/1ps
// host user side driven, both ends watched
module mprs_bench;
    localparam int INIT  = 200; // shortened start-up interval
    localparam int CFG   = 20;
    localparam int SHUT  = 50;
    localparam int HOLD  = 10;
    localparam int LIMIT = 3000; // about two and a half times the expected run
    logic clk, rst_n, supply_en, restart_req, shutdown_req, radio_off;
    logic ready, start_fail, powered_off, active, off;
    int   err_total, checks_done, cyc, n;

    mprs_if i_mprs_if ();
    mprs_card #(.INIT_CYC(INIT), .CFG_CYC(CFG), .SHUT_CYC(SHUT)) i_mprs_card (.CLK(clk),
        .RST_N(rst_n), .PINS(i_mprs_if.card), .ACTIVE(active), .OFF(off));
    mprs_host #(.INIT_CYC(INIT), .HOLD_CYC(HOLD)) i_mprs_host (.CLK(clk), .RST_N(rst_n),
        .PINS(i_mprs_if.host), .SUPPLY_EN(supply_en), .RESTART_REQ(restart_req),
        .SHUTDOWN_REQ(shutdown_req), .RADIO_OFF(radio_off), .READY(ready),
        .START_FAIL(start_fail), .POWERED_OFF(powered_off));
    mprs_monitor #(.INIT_CYC(INIT), .CFG_CYC(CFG), .SHUT_CYC(SHUT), .HOLD_CYC(HOLD))
        i_mprs_monitor (.CLK(clk), .RST_N(rst_n),
        .main_supply_input(i_mprs_if.main_supply_input),
        .card_reset_n_oe(i_mprs_if.card_reset_n_oe), .card_reset_n(i_mprs_if.card_reset_n),
        .radio_disable_n(i_mprs_if.radio_disable_n),
        .power_monitor_output(i_mprs_if.power_monitor_output),
        .shutdown_command(i_mprs_if.shutdown_command), .cmd_ready(i_mprs_if.cmd_ready));

    // free-running clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // inputs only move on falling edges
    task automatic step(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic pulse(ref logic r);
        r = 1'b1;
        step(1);
        r = 1'b0;
    endtask

    // bounded wait, n returns cycles spent
    task automatic wait_hi(ref logic s, input int lim);
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            step(1);
            n++;
        end
    endtask

    task automatic stop_test();
        $display("mismatches %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        {rst_n, supply_en, restart_req, shutdown_req, radio_off} = '0;
        {err_total, checks_done, cyc, n} = '0;
        step(5);
        rst_n = 1'b1;
        check("card off at reset", 1, off);
        // start-up; an early shutdown request must be refused
        supply_en = 1'b1;
        step(CFG + 10);
        check("monitor after config", 1, i_mprs_if.power_monitor_output);
        check("no access in init", 0, active);
        check("radio enabled at start", 1, i_mprs_if.radio_disable_n);
        pulse(restart_req);
        check("restart refused in init", 1, i_mprs_if.card_reset_n);
        pulse(shutdown_req);
        wait_hi(ready, 2 * INIT);
        check("start-up time", 1, n + CFG + 12 >= INIT);
        check("host ready", 1, ready);
        check("card active", 1, active);
        // emergency restart with radio enabled
        pulse(restart_req);
        step(4);
        check("reset line low", 0, i_mprs_if.card_reset_n);
        step(4);
        check("halted in reset", 0, active);
        wait_hi(ready, 2 * INIT);
        check("restart comes back", 1, active);
        check("reset line released", 1, i_mprs_if.card_reset_n);
        // orderly shutdown, radio held disabled so it stays off
        radio_off = 1'b1;
        pulse(shutdown_req);
        wait_hi(powered_off, 4 * SHUT);
        check("finalization length", 1, n >= SHUT);
        check("host saw power-off", 1, powered_off);
        check("monitor low at power-off", 0, i_mprs_if.power_monitor_output);
        check("card stays off", 1, off);
        step(4);
        check("supply removed", 0, i_mprs_if.main_supply_input);
        // restart with radio disabled must leave the card down
        supply_en = 1'b0;
        radio_off = 1'b0;
        step(4);
        supply_en = 1'b1;
        wait_hi(ready, 2 * INIT);
        radio_off = 1'b1;
        pulse(restart_req);
        step(2 * INIT + 40);
        check("down after restart", 1, off);
        check("monitor low", 0, i_mprs_if.power_monitor_output);
        check("start failure flagged", 1, start_fail);
        stop_test();
    end
endmodule
